// >>> src/imp_sweep_params.svh
// Register offsets, field positions, reset value and frequency shift of the sweep control block
`ifndef IMP_SWEEP_PARAMS_SVH
`define IMP_SWEEP_PARAMS_SVH
`define ADDR_CTRL_HI 8'h80
`define ADDR_CTRL_LO 8'h81
`define ADDR_START_0 8'h82
`define ADDR_START_1 8'h83
`define ADDR_START_2 8'h84
`define ADDR_STEP_0 8'h85
`define ADDR_STEP_1 8'h86
`define ADDR_STEP_2 8'h87
`define ADDR_POINTS_0 8'h88
`define ADDR_POINTS_1 8'h89
`define ADDR_SETTLE_0 8'h8A
`define ADDR_SETTLE_1 8'h8B
`define ADDR_FLAGS 8'h8F
`define ADDR_TEMP_0 8'h92
`define ADDR_TEMP_1 8'h93
`define ADDR_INPH_0 8'h94
`define ADDR_INPH_1 8'h95
`define ADDR_QUAD_0 8'h96
`define ADDR_QUAD_1 8'h97
`define CTRL_RESET_VAL 16'hA000
`define CTRL_CMD_MSB 15
`define CTRL_CMD_LSB 12
`define CTRL_RANGE_MSB 10
`define CTRL_RANGE_LSB 9
`define CTRL_GAIN_BIT 8
`define CTRL_RESET_BIT 4
`define CTRL_CLKSRC_BIT 3
`define FLAG_TEMP_BIT 0
`define FLAG_DATA_BIT 1
`define FLAG_SWEEP_BIT 2
`define SETTLE_MULT_MSB 10
`define SETTLE_MULT_LSB 9
`define SETTLE_CNT_MSB 8
`define POINTS_MSB 8
`define FREQ_SHIFT 27
`endif

// >>> src/imp_sweep_pkg.sv
// Types of the sweep control block
`default_nettype none
package imp_sweep_pkg;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_INIT = 4'h1,
		CMD_START = 4'h2,
		CMD_INCR = 4'h3,
		CMD_REPEAT = 4'h4,
		CMD_TEMP = 4'h9,
		CMD_PDOWN = 4'hA,
		CMD_STBY = 4'hB
	} cmd_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_HOLD = 6'b000010,
		ST_SETTLE = 6'b000100,
		ST_CONVERT = 6'b001000,
		ST_DONE = 6'b010000,
		ST_TEMP = 6'b100000
	} state_t;
	typedef enum logic [1:0] {
		PWR_DOWN = 2'h0,
		PWR_STBY = 2'h1,
		PWR_ON = 2'h2
	} power_t;
endpackage
`default_nettype wire

// >>> src/impedance_sweep_control_regs.sv
// Register bank and control-word decoder of the impedance sweep engine
`timescale 1ns/1ps
`default_nettype none
`include "imp_sweep_params.svh"
module impedance_sweep_control_regs #(
	parameter int PHASE_W = 27
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic excitationCycle,
	output logic convStart,
	input wire logic convDone,
	input wire logic [15:0] inphaseIn,
	input wire logic [15:0] quadratureIn,
	output logic tempStart,
	input wire logic tempDone,
	input wire logic [13:0] tempIn,
	output logic tempPowerOn,
	output logic [PHASE_W-1:0] phaseStep,
	output logic synthEnable,
	output logic [1:0] excitationRange,
	output logic gainUnity,
	output logic clkExternal,
	output logic coreActive,
	output logic excitationOutputGround,
	output logic responseInputGround
);

	// ****************************************
	// Register state
	// ****************************************
	logic [15:0] ctrl_q, ctrl_d;
	logic [23:0] start_q, start_d, step_q, step_d, freq_q, freq_d;
	logic [15:0] points_q, points_d, settle_q, settle_d;
	logic [15:0] temp_q, temp_d, inph_q, inph_d, quad_q, quad_d;
	logic [2:0] flags_q, flags_d;
	logic [8:0] pointIdx_q, pointIdx_d;
	logic [10:0] settleCnt_q, settleCnt_d;
	imp_sweep_pkg::state_t state_q, state_d;
	imp_sweep_pkg::power_t power_q, power_d;
	logic cmdPulse;
	logic [3:0] cmdCode;
	logic [10:0] settleTarget;

	// Decode of the command field
	function automatic imp_sweep_pkg::cmd_t decodeCmd(input logic [3:0] code);
		case (code)
			4'h1: decodeCmd = imp_sweep_pkg::CMD_INIT;
			4'h2: decodeCmd = imp_sweep_pkg::CMD_START;
			4'h3: decodeCmd = imp_sweep_pkg::CMD_INCR;
			4'h4: decodeCmd = imp_sweep_pkg::CMD_REPEAT;
			4'h9: decodeCmd = imp_sweep_pkg::CMD_TEMP;
			4'hA: decodeCmd = imp_sweep_pkg::CMD_PDOWN;
			4'hB: decodeCmd = imp_sweep_pkg::CMD_STBY;
			default: decodeCmd = imp_sweep_pkg::CMD_NOP;
		endcase
	endfunction

	// Sweep armed only after initialize; temperature reading keeps it unarmed
	function automatic logic sweepArmed(input imp_sweep_pkg::state_t st);
		sweepArmed = (st != imp_sweep_pkg::ST_IDLE) && (st != imp_sweep_pkg::ST_TEMP);
	endfunction

	// Command fires on every write of the upper control byte
	assign cmdPulse = regWrite && (regAddr == `ADDR_CTRL_HI);
	assign cmdCode = regWdata[`CTRL_CMD_MSB-8:`CTRL_CMD_LSB-8];

	// Settling count scaled by one, two or four
	always_comb begin
		settleTarget = {2'h0, settle_q[`SETTLE_CNT_MSB:0]};
		case (settle_q[`SETTLE_MULT_MSB:`SETTLE_MULT_LSB])
			2'b01: settleTarget = {1'b0, settle_q[`SETTLE_CNT_MSB:0], 1'b0};
			2'b11: settleTarget = {settle_q[`SETTLE_CNT_MSB:0], 2'b00};
			default: settleTarget = {2'h0, settle_q[`SETTLE_CNT_MSB:0]};
		endcase
	end

	// ****************************************
	// Register writes and sweep sequencer
	// ****************************************
	always_comb begin
		ctrl_d = ctrl_q;
		start_d = start_q;
		step_d = step_q;
		points_d = points_q;
		settle_d = settle_q;
		temp_d = temp_q;
		inph_d = inph_q;
		quad_d = quad_q;
		flags_d = flags_q;
		freq_d = freq_q;
		pointIdx_d = pointIdx_q;
		settleCnt_d = settleCnt_q;
		state_d = state_q;
		power_d = power_q;
		// Byte writes, most significant byte at the lowest address
		if (regWrite) begin
			case (regAddr)
				`ADDR_CTRL_HI: ctrl_d[15:8] = regWdata;
				`ADDR_CTRL_LO: ctrl_d[7:0] = regWdata;
				`ADDR_START_0: start_d[23:16] = regWdata;
				`ADDR_START_1: start_d[15:8] = regWdata;
				`ADDR_START_2: start_d[7:0] = regWdata;
				`ADDR_STEP_0: step_d[23:16] = regWdata;
				`ADDR_STEP_1: step_d[15:8] = regWdata;
				`ADDR_STEP_2: step_d[7:0] = regWdata;
				`ADDR_POINTS_0: points_d[15:8] = regWdata;
				`ADDR_POINTS_1: points_d[7:0] = regWdata;
				`ADDR_SETTLE_0: settle_d[15:8] = regWdata;
				`ADDR_SETTLE_1: settle_d[7:0] = regWdata;
				default: ;
			endcase
		end
		// Sequencer progress
		case (state_q)
			imp_sweep_pkg::ST_SETTLE: begin
				if (excitationCycle) begin
					if (settleCnt_q >= settleTarget) begin
						state_d = imp_sweep_pkg::ST_CONVERT;
					end else begin
						settleCnt_d = settleCnt_q + 11'h001;
					end
				end
			end
			imp_sweep_pkg::ST_CONVERT: begin
				if (convDone) begin
					inph_d = inphaseIn;
					quad_d = quadratureIn;
					flags_d[`FLAG_DATA_BIT] = 1'b1;
					if (pointIdx_q >= points_q[`POINTS_MSB:0]) begin
						flags_d[`FLAG_SWEEP_BIT] = 1'b1;
					end
					state_d = imp_sweep_pkg::ST_DONE;
				end
			end
			imp_sweep_pkg::ST_TEMP: begin
				if (tempDone) begin
					temp_d = {{2{tempIn[13]}}, tempIn};
					flags_d[`FLAG_TEMP_BIT] = 1'b1;
					state_d = imp_sweep_pkg::ST_IDLE;
				end
			end
			imp_sweep_pkg::ST_IDLE, imp_sweep_pkg::ST_HOLD, imp_sweep_pkg::ST_DONE: ;
			default: state_d = imp_sweep_pkg::ST_IDLE;
		endcase
		// Commands; a new command overrides the sequencer
		if (cmdPulse) begin
			case (decodeCmd(cmdCode))
				imp_sweep_pkg::CMD_INIT: begin
					freq_d = start_q;
					pointIdx_d = 9'h000;
					power_d = imp_sweep_pkg::PWR_ON;
					state_d = imp_sweep_pkg::ST_HOLD;
				end
				imp_sweep_pkg::CMD_START: begin
					if (sweepArmed(state_q)) begin
						settleCnt_d = 11'h000;
						state_d = imp_sweep_pkg::ST_SETTLE;
					end
					flags_d[`FLAG_DATA_BIT] = 1'b0;
				end
				imp_sweep_pkg::CMD_INCR: begin
					if (sweepArmed(state_q)) begin
						freq_d = freq_q + step_q;
						pointIdx_d = pointIdx_q + 9'h001;
						settleCnt_d = 11'h000;
						state_d = imp_sweep_pkg::ST_SETTLE;
					end
					flags_d[`FLAG_DATA_BIT] = 1'b0;
				end
				imp_sweep_pkg::CMD_REPEAT: begin
					if (sweepArmed(state_q)) begin
						settleCnt_d = 11'h000;
						state_d = imp_sweep_pkg::ST_SETTLE;
					end
					flags_d[`FLAG_DATA_BIT] = 1'b0;
				end
				imp_sweep_pkg::CMD_TEMP: begin
					flags_d[`FLAG_TEMP_BIT] = 1'b0;
					if (state_q == imp_sweep_pkg::ST_IDLE || state_q == imp_sweep_pkg::ST_DONE) begin
						state_d = imp_sweep_pkg::ST_TEMP;
					end
				end
				imp_sweep_pkg::CMD_PDOWN: begin
					power_d = imp_sweep_pkg::PWR_DOWN;
					state_d = imp_sweep_pkg::ST_IDLE;
				end
				imp_sweep_pkg::CMD_STBY: begin
					power_d = imp_sweep_pkg::PWR_STBY;
					state_d = imp_sweep_pkg::ST_IDLE;
				end
				default: ;
			endcase
		end
		// Reset bit: abort the sweep, sweep setup registers untouched
		if (regWrite && regAddr == `ADDR_CTRL_LO && regWdata[`CTRL_RESET_BIT]) begin
			state_d = imp_sweep_pkg::ST_IDLE;
			flags_d[`FLAG_DATA_BIT] = 1'b0;
			flags_d[`FLAG_SWEEP_BIT] = 1'b0;
		end
	end

	// Register update; setup words have no reset value
	always_ff @(posedge clk_sys) begin
		start_q <= start_d;
		step_q <= step_d;
		points_q <= points_d;
		settle_q <= settle_d;
		freq_q <= freq_d;
		inph_q <= inph_d;
		quad_q <= quad_d;
		temp_q <= temp_d;
		if (sys_rst) begin
			ctrl_q <= `CTRL_RESET_VAL;
			flags_q <= 3'h0;
			pointIdx_q <= 9'h000;
			settleCnt_q <= 11'h000;
			state_q <= imp_sweep_pkg::ST_IDLE;
			power_q <= imp_sweep_pkg::PWR_DOWN;
		end else begin
			ctrl_q <= ctrl_d;
			flags_q <= flags_d;
			pointIdx_q <= pointIdx_d;
			settleCnt_q <= settleCnt_d;
			state_q <= state_d;
			power_q <= power_d;
		end
	end

	// ****************************************
	// Read path and outputs
	// ****************************************
	always_comb begin
		case (regAddr)
			`ADDR_CTRL_HI: regRdata = ctrl_q[15:8];
			`ADDR_CTRL_LO: regRdata = ctrl_q[7:0];
			`ADDR_START_0: regRdata = start_q[23:16];
			`ADDR_START_1: regRdata = start_q[15:8];
			`ADDR_START_2: regRdata = start_q[7:0];
			`ADDR_STEP_0: regRdata = step_q[23:16];
			`ADDR_STEP_1: regRdata = step_q[15:8];
			`ADDR_STEP_2: regRdata = step_q[7:0];
			`ADDR_POINTS_0: regRdata = points_q[15:8];
			`ADDR_POINTS_1: regRdata = points_q[7:0];
			`ADDR_SETTLE_0: regRdata = settle_q[15:8];
			`ADDR_SETTLE_1: regRdata = settle_q[7:0];
			`ADDR_FLAGS: regRdata = {5'h00, flags_q};
			`ADDR_TEMP_0: regRdata = temp_q[15:8];
			`ADDR_TEMP_1: regRdata = temp_q[7:0];
			`ADDR_INPH_0: regRdata = inph_q[15:8];
			`ADDR_INPH_1: regRdata = inph_q[7:0];
			`ADDR_QUAD_0: regRdata = quad_q[15:8];
			`ADDR_QUAD_1: regRdata = quad_q[7:0];
			default: regRdata = 8'h00;
		endcase
	end

	// Phase increment in clock/4 units over two to the 27
	assign phaseStep = PHASE_W'(freq_q);
	assign synthEnable = sweepArmed(state_q);
	assign convStart = (state_q == imp_sweep_pkg::ST_CONVERT);
	assign tempStart = (state_q == imp_sweep_pkg::ST_TEMP);
	assign tempPowerOn = (state_q == imp_sweep_pkg::ST_TEMP);
	assign excitationRange = ctrl_q[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB];
	assign gainUnity = ctrl_q[`CTRL_GAIN_BIT];
	assign clkExternal = ctrl_q[`CTRL_CLKSRC_BIT];
	assign coreActive = (power_q != imp_sweep_pkg::PWR_DOWN);
	// Pins grounded unless fully on
	assign excitationOutputGround = (power_q != imp_sweep_pkg::PWR_ON);
	assign responseInputGround = (power_q != imp_sweep_pkg::PWR_ON);

endmodule
`default_nettype wire

// >>> test/sweep_ctrl_checker.sv
// Assertion checker of the sweep control block
`timescale 1ns/1ps
`default_nettype none
module sweep_ctrl_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic convStart,
	input wire logic convDone,
	input wire logic synthEnable,
	input wire logic [1:0] excitationRange,
	input wire logic gainUnity,
	input wire logic clkExternal,
	input wire logic coreActive,
	input wire logic excitationOutputGround,
	input wire logic responseInputGround
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Decoded upper control byte writes and pin ties
	wire logic hiWr = regWrite && regAddr == 8'h80;
	wire logic [3:0] cmd = regWdata[7:4];
	wire logic og = excitationOutputGround;
	wire logic ig = responseInputGround;
	property p_boot; $fell(sys_rst) |-> og && ig && !coreActive && !convStart; endproperty
	property p_init; hiWr && cmd == 4'h1 |=> synthEnable && !og && !ig && !convStart; endproperty
	property p_range;
		hiWr |=> excitationRange == $past(regWdata[2:1]) && gainUnity == $past(regWdata[0]);
	endproperty
	property p_clk; regWrite && regAddr == 8'h81 |=> clkExternal == $past(regWdata[3]); endproperty
	property p_conv; convStart && convDone |=> !convStart; endproperty
	property p_pdown; hiWr && cmd == 4'hA |=> og && ig && !coreActive && !synthEnable; endproperty
	property p_stby; hiWr && cmd == 4'hB |=> og && ig && coreActive && !synthEnable; endproperty
	property p_rst; regWrite && regAddr == 8'h81 && regWdata[4] |=> !synthEnable && !convStart;
	endproperty
	property p_nop;
		hiWr && cmd inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF}
			|=> $stable(synthEnable) && $stable(coreActive);
	endproperty
	property p_armed;
		hiWr && cmd inside {4'h2, 4'h3, 4'h4} && !synthEnable |=> !synthEnable && !convStart;
	endproperty
	a_boot: assert property (p_boot) else $error("start-up state wrong");
	a_init: assert property (p_init) else $error("initialize did not hold frequency");
	a_range: assert property (p_range) else $error("range or gain not taken");
	a_clk: assert property (p_clk) else $error("clock source not taken");
	a_conv: assert property (p_conv) else $error("conversion did not end");
	a_pdown: assert property (p_pdown) else $error("power-down state wrong");
	a_stby: assert property (p_stby) else $error("standby state wrong");
	a_rst: assert property (p_rst) else $error("reset did not abort");
	a_nop: assert property (p_nop) else $error("no-operation changed state");
	a_armed: assert property (p_armed) else $error("sweep resumed without initialize");
	c_conv: cover property (convStart && convDone);
	c_rst: cover property (regWrite && regAddr == 8'h81 && regWdata[4]);
	c_stby: cover property (hiWr && cmd == 4'hB);
endmodule
bind impedance_sweep_control_regs sweep_ctrl_checker sweep_ctrl_checker_inst (.clk_sys, .sys_rst,
	.regWrite, .regAddr, .regWdata, .convStart, .convDone, .synthEnable, .excitationRange,
	.gainUnity, .clkExternal, .coreActive, .excitationOutputGround, .responseInputGround);
`default_nettype wire

// >>> test/sweep_far_model.sv
// Model of synthesizer, converter and temperature sensor
`timescale 1ns/1ps
`default_nettype none
module sweep_far_model (
	input wire logic clk_sys,
	input wire logic synthEnable,
	input wire logic convStart,
	input wire logic tempStart,
	output logic excitationCycle,
	output logic convDone,
	output logic [15:0] inphaseIn,
	output logic [15:0] quadratureIn,
	output logic tempDone,
	output logic [13:0] tempIn
);
	// ****
	// Far side timing
	// ****
	logic [1:0] div_q;
	logic [2:0] conv_q;
	logic [2:0] temp_q;
	// Cycle tick every four clocks, conversion and reading delays
	always_ff @(posedge clk_sys) begin
		div_q <= synthEnable ? div_q + 2'h1 : 2'h0;
		conv_q <= convStart ? conv_q + {2'h0, conv_q != 3'h7} : 3'h0;
		temp_q <= tempStart ? temp_q + {2'h0, temp_q != 3'h7} : 3'h0;
	end
	// Data valid only in the done cycle, inverted otherwise
	assign excitationCycle = synthEnable && div_q == 2'h3;
	assign convDone = convStart && conv_q == 3'h5;
	assign tempDone = tempStart && temp_q == 3'h3;
	assign inphaseIn = convDone ? 16'h1C2B : 16'hE3D4;
	assign quadratureIn = convDone ? 16'h6E71 : 16'h918E;
	assign tempIn = tempDone ? 14'h3F2A : 14'h00D5;
endmodule
`default_nettype wire

// >>> test/test_impedance_sweep_control_regs.sv
// Self-checking bench of the sweep control register block
`timescale 1ns/1ps
`default_nettype none
module test_impedance_sweep_control_regs;
	// ****
	// Stimulus and checks
	// ****
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic regWrite = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic excitationCycle, convStart, convDone, tempStart, tempDone, tempPowerOn;
	logic [15:0] inphaseIn, quadratureIn;
	logic [13:0] tempIn;
	logic [26:0] phaseStep;
	logic synthEnable, gainUnity, clkExternal, coreActive, og, ig;
	logic [1:0] excitationRange;
	int bad_count = 0;
	int n_tests = 0;
	impedance_sweep_control_regs impedance_sweep_control_regs_inst (.clk_sys, .sys_rst,
		.regWrite, .regAddr, .regWdata, .regRdata, .excitationCycle, .convStart, .convDone,
		.inphaseIn, .quadratureIn, .tempStart, .tempDone, .tempIn, .tempPowerOn, .phaseStep,
		.synthEnable, .excitationRange, .gainUnity, .clkExternal, .coreActive,
		.excitationOutputGround(og), .responseInputGround(ig));
	sweep_far_model sweep_far_model_inst (.clk_sys, .synthEnable, .convStart, .tempStart,
		.excitationCycle, .convDone, .inphaseIn, .quadratureIn, .tempDone, .tempIn);
	// Clock
	initial forever #10 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Byte write, address parked on the flags afterwards
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		regAddr <= 8'h8F;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm,
		input logic [7:0] m = 8'hFF);
		@(posedge clk_sys);
		regAddr <= a;
		#1;
		chk(nm, {24'h0, e}, {24'h0, regRdata & m});
	endtask
	// Count settling ticks until conversion, then check flags and results
	task automatic meas(input logic [7:0] mid, input logic [7:0] fin,
		input logic [31:0] np = 32'd4);
		int n = 0;
		int t = 0;
		chk("mid flags", {24'h0, mid}, {24'h0, regRdata});
		while (convStart !== 1'b1 && t < 300) begin
			@(negedge clk_sys);
			n += int'(excitationCycle);
			t++;
		end
		chk("settle", np, n);
		while (convStart !== 1'b0 && t < 300) begin
			@(negedge clk_sys);
			t++;
		end
		chk("meas time", 32'h1, {31'h0, t < 300});
		rd(8'h8F, fin, "flags");
		rd(8'h94, 8'h1C, "inphase");
		rd(8'h97, 8'h71, "quad");
	endtask
	task automatic t_boot;
		rd(8'h80, 8'hA0, "ctrl hi");
		rd(8'h81, 8'h00, "ctrl lo");
		rd(8'h8F, 8'h00, "flags");
		chk("pins", 32'h6, {29'h0, og, ig, coreActive});
	endtask
	task automatic t_setup;
		logic [7:0] v [10] = '{8'h0F, 8'h5C, 8'h28, 8'h00, 8'h01, 8'h4F, 8'h00, 8'h01, 8'h00, 8'h03};
		foreach (v[i]) wr(8'h82 + 8'(i), v[i]);
		foreach (v[i]) rd(8'h82 + 8'(i), v[i], "setup");
		wr(8'h81, 8'h08);
		chk("clk src", 32'h1, {31'h0, clkExternal});
		for (int i = 0; i < 8; i++) begin
			wr(8'h80, 8'(i));
			chk("range", 32'(i / 2), {30'h0, excitationRange});
			chk("gain", 32'(i % 2), {31'h0, gainUnity});
		end
		rd(8'h81, 8'h08, "lo kept");
		rd(8'h8C, 8'h00, "unmapped");
	endtask
	task automatic t_temp;
		int t = 0;
		wr(8'h80, 8'h90);
		chk("temp on", 32'h3, {30'h0, tempStart, tempPowerOn});
		while (tempStart !== 1'b0 && t < 50) begin
			@(negedge clk_sys);
			t++;
		end
		chk("temp time", 32'h1, {31'h0, t < 50});
		rd(8'h92, 8'h3F, "temp hi", 8'h3F);
		rd(8'h93, 8'h2A, "temp lo");
		rd(8'h8F, 8'h01, "temp flag");
		chk("pins", 32'hC, {28'h0, og, ig, coreActive, tempPowerOn});
	endtask
	task automatic t_sweep;
		logic [3:0] nops [6] = '{4'h0, 4'h8, 4'hC, 4'hD, 4'h6, 4'hF};
		wr(8'h80, 8'h10);
		chk("init", 32'h2, {29'h0, convStart, synthEnable, og});
		foreach (nops[i]) begin
			wr(8'h80, {nops[i], 4'h0});
			chk("nop", 32'h2, {29'h0, convStart, synthEnable, og});
		end
		wr(8'h80, 8'h20);
		meas(8'h01, 8'h03);
		chk("start f", 32'h0F5C28, {5'h0, phaseStep});
		wr(8'h80, 8'h30);
		meas(8'h01, 8'h07);
		chk("step f", 32'h0F5D77, {5'h0, phaseStep});
		wr(8'h80, 8'h40);
		meas(8'h05, 8'h07);
		chk("rep f", 32'h0F5D77, {5'h0, phaseStep});
		wr(8'h94, 8'hFF);
		rd(8'h94, 8'h1C, "read only");
	endtask
	task automatic t_reset;
		wr(8'h81, 8'h18);
		rd(8'h8F, 8'h01, "rst flags");
		rd(8'h84, 8'h28, "keep start");
		rd(8'h87, 8'h4F, "keep step");
		rd(8'h89, 8'h01, "keep count");
		wr(8'h80, 8'h90);
		wr(8'h80, 8'h20);
		repeat (40) @(negedge clk_sys);
		chk("no resume", 32'h0, {30'h0, convStart, synthEnable});
		wr(8'h8A, 8'h06);
		wr(8'h80, 8'h10);
		wr(8'h80, 8'h20);
		meas(8'h01, 8'h03, 32'd13);
		chk("restart f", 32'h0F5C28, {5'h0, phaseStep});
		wr(8'h8A, 8'h02);
		wr(8'h80, 8'h40);
		meas(8'h01, 8'h03, 32'd7);
	endtask
	task automatic t_power;
		logic [3:0] cmd [3] = '{4'hB, 4'hC, 4'hA};
		logic [2:0] want [3] = '{3'h7, 3'h7, 3'h6};
		chk("on", 32'h1, {29'h0, og, ig, coreActive});
		foreach (cmd[i]) begin
			wr(8'h80, {cmd[i], 4'h0});
			chk("power", {29'h0, want[i]}, {29'h0, og, ig, coreActive});
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_boot();
		t_setup();
		t_temp();
		t_sweep();
		t_reset();
		t_power();
		stop_test();
	end
endmodule
`default_nettype wire
